// ### design/cpdt_top.sv
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "cpdt_regs.svh"

// Overview of operation
// RL1 - cut down dwell 1 to 9999 ms, cut output held that long
// RL2 - zero cut dwell: feed-to-stop line held until cut switch closes
// RL3 - zero cut dwell: no switch in 10 s halts line, flags error
// RL4 - cut switch closing in the stroke drops cut output at once
// RL5 - non-stop line, zero dwell: runs 10 s, then halts with error
// RL6 - cut up output timed by its own up dwell
// RL7 - combined mode: cut dwell is down time, same time for up
// RL8 - combined mode: fitted cut switch ends down time early
// RL9 - zero early start: cut fires only at minimum die travel
// RL10 - early start 0 to 500 ms fires cut ahead of die target
// RL11 - cut never fires before the die acceleration ramp begins
// RL12 - tolerance check pulsed at end of cut down dwell
// RL13 - early start used only with cut-and-stop or warn-only
// RL14 - each press has its own down dwell setting its cycle
// RL15 - press down dwell settable 1 to 9999 ms
// RL16 - fitted press switch closing ends that press down dwell
// RL17 - each press up output timed by its own up dwell
// RL18 - combined mode: press down time reused as press up time
// RL19 - operator sets cut dwell a bit above switch close time
// RL20 - cut and press outputs are timed pulses firing downward
// RL21 - all dwells and timeouts count one shared 1 ms tick

module cpdt_top #(
  parameter int TICK_CYCLES = `CPDT_TICK_CYC
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              cut_req,
  input  wire logic              die_ramp,
  input  wire logic              die_at_min,
  input  wire logic [8:0]        die_eta_ms,
  input  wire logic              cut_sw_pin,
  input  wire logic [3:0]        press_req,
  input  wire logic [3:0]        press_sw_pin,
  output cpdt_pkg::cpdt_sol_s    solenoids,
  output logic                   tol_check,
  output logic                   line_halt,
  output logic                   error_flag,
  output logic                   restart_inhibit
);

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);

  localparam cpdt_pkg::cpdt_prs_s PRS_RST = '{
    st:  cpdt_pkg::PS_IDLE,
    cnt: 14'h0000,
    len: 14'h0000
  };

  localparam cpdt_pkg::cpdt_ctl_s CTL_RST = '{
    prs_sw_fit: 4'h0,
    tol_act:    cpdt_pkg::TOL_CUT_STOP,
    cut_sw_fit: 1'b0,
    combined:   1'b0,
    nonstop:    1'b0,
    enable:     1'b0
  };

  localparam cpdt_pkg::cpdt_state_s S_RST = '{
    ctl:       CTL_RST,
    cut_dn:    `CPDT_DWELL_RST,
    cut_up:    `CPDT_DWELL_RST,
    early:     `CPDT_EARLY_RST,
    prs_dn:    {4{`CPDT_DWELL_RST}},
    prs_up:    {4{`CPDT_DWELL_RST}},
    tick_cnt:  15'h0000,
    tick:      1'b0,
    cut_st:    cpdt_pkg::CS_IDLE,
    cut_cnt:   14'h0000,
    up_len:    14'h0000,
    err:       1'b0,
    halt:      1'b0,
    tol_pulse: 1'b0,
    prs:       {4{PRS_RST}},
    cut_sw1:   1'b0,
    cut_sw2:   1'b0,
    prs_sw1:   4'h0,
    prs_sw2:   4'h0,
    wr_pend:   1'b0,
    a_addr:    8'h00,
    rdata:     32'h0000_0000
  };

  // ****************************************************************
  // helpers
  // ****************************************************************
  // clamp a written dwell into its legal window
  function automatic logic [13:0] clamp_dwell(
    input logic [31:0] v,
    input logic [13:0] lo
  );
    return (v[31:14] != 18'h00000 || v[13:0] > `CPDT_DWELL_MAX) ?
           `CPDT_DWELL_MAX : ((v[13:0] < lo) ? lo : v[13:0]);
  endfunction : clamp_dwell

  // word seen by a read at byte offset a
  function automatic logic [31:0] read_word(
    input logic [7:0]           a,
    input cpdt_pkg::cpdt_state_s s,
    input logic                 inhibit
  );
    logic [31:0] w;
    logic [3:0]  pbusy;
    w = 32'h0000_0000;
    for (int k = 0; k < 4; k++)
    begin
      pbusy[k] = (s.prs[k].st != cpdt_pkg::PS_IDLE);
    end
    if (a == `CPDT_CTRL_OFS)
    begin
      w[`CPDT_CTRL_W-1:0] = s.ctl;
    end
    else if (a == `CPDT_CUT_DN_OFS)
    begin
      w[`CPDT_DWELL_W-1:0] = s.cut_dn;
    end
    else if (a == `CPDT_CUT_UP_OFS)
    begin
      w[`CPDT_DWELL_W-1:0] = s.cut_up;
    end
    else if (a == `CPDT_EARLY_OFS)
    begin
      w[`CPDT_EARLY_W-1:0] = s.early;
    end
    else if (a == `CPDT_STATUS_OFS)
    begin
      w[7:0] = {pbusy, (s.cut_st != cpdt_pkg::CS_IDLE),
                inhibit, s.halt, s.err};
    end
    else if (a[7:4] == `CPDT_PDN_BASE)
    begin
      w[`CPDT_DWELL_W-1:0] = s.prs_dn[a[3:2]];
    end
    else if (a[7:4] == `CPDT_PUP_BASE)
    begin
      w[`CPDT_DWELL_W-1:0] = s.prs_up[a[3:2]];
    end
    return w;
  endfunction : read_word

  // ****************************************************************
  // state
  // ****************************************************************
  cpdt_pkg::cpdt_state_s s_reg;
  cpdt_pkg::cpdt_state_s s_next;
  logic                  zero_dn;
  logic                  inhibit;
  logic                  early_ok;
  logic [8:0]            early_eff;
  logic                  early_hit;
  logic                  addr_ok;

  // decode of cut and bus conditions
  always_comb
  begin
    zero_dn   = (s_reg.cut_dn == 14'h0000);
    inhibit   = (s_reg.cut_st == cpdt_pkg::CS_DOWN) && zero_dn &&
                !s_reg.ctl.nonstop;                             // [RL2]
    early_ok  = (s_reg.ctl.tol_act == cpdt_pkg::TOL_CUT_STOP) ||
                (s_reg.ctl.tol_act == cpdt_pkg::TOL_WARN);      // [RL13]
    early_eff = early_ok ? s_reg.early : 9'h000;
    early_hit = (early_eff != 9'h000) &&
                (die_eta_ms <= early_eff);                      // [RL10]
    addr_ok   = hsel && htrans[1] && hready && (hsize == 3'h2);
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_next           = s_reg;
    s_next.tol_pulse = 1'b0;

    // switch pins pass two flops before anything looks at them
    s_next.cut_sw1 = cut_sw_pin;
    s_next.cut_sw2 = s_reg.cut_sw1;
    s_next.prs_sw1 = press_sw_pin;
    s_next.prs_sw2 = s_reg.prs_sw1;

    // shared millisecond time base; one tick pulse per wrap
    s_next.tick     = (s_reg.tick_cnt == TICK_LAST);            // [RL21]
    s_next.tick_cnt = s_next.tick ? 15'h0000 : s_reg.tick_cnt + 15'h0001;

    // bus address phase; read data is caught here so it is a flop
    s_next.wr_pend = addr_ok && hwrite;
    if (addr_ok)
    begin
      s_next.a_addr = haddr[7:0];
      if (!hwrite)
      begin
        s_next.rdata = read_word(haddr[7:0], s_reg, inhibit);
      end
    end

    // bus data phase write; clear of error loses to a new event
    if (s_reg.wr_pend)
    begin
      if (s_reg.a_addr == `CPDT_CTRL_OFS)
      begin
        s_next.ctl = cpdt_pkg::cpdt_ctl_s'(hwdata[`CPDT_CTRL_W-1:0]);
      end
      else if (s_reg.a_addr == `CPDT_CUT_DN_OFS)
      begin
        s_next.cut_dn = (hwdata == 32'h0000_0000) ? 14'h0000 :
                        clamp_dwell(hwdata, `CPDT_DWELL_MIN);   // [RL1]
      end
      else if (s_reg.a_addr == `CPDT_CUT_UP_OFS)
      begin
        s_next.cut_up = clamp_dwell(hwdata, 14'h0000);
      end
      else if (s_reg.a_addr == `CPDT_EARLY_OFS)
      begin
        s_next.early = (hwdata > 32'(`CPDT_EARLY_MAX)) ?
                       `CPDT_EARLY_MAX : hwdata[8:0];           // [RL10]
      end
      else if (s_reg.a_addr == `CPDT_STATUS_OFS)
      begin
        if (hwdata[`CPDT_STS_CLR_BIT])
        begin
          s_next.err  = 1'b0;
          s_next.halt = 1'b0;
        end
      end
      else if (s_reg.a_addr[7:4] == `CPDT_PDN_BASE)
      begin
        s_next.prs_dn[s_reg.a_addr[3:2]] =
          clamp_dwell(hwdata, `CPDT_DWELL_MIN);                 // [RL15]
      end
      else if (s_reg.a_addr[7:4] == `CPDT_PUP_BASE)
      begin
        s_next.prs_up[s_reg.a_addr[3:2]] =
          clamp_dwell(hwdata, 14'h0000);
      end
    end

    // cut stroke
    unique case (s_reg.cut_st)
      cpdt_pkg::CS_IDLE:
      begin
        if (cut_req && s_reg.ctl.enable)
        begin
          s_next.cut_st = cpdt_pkg::CS_ARM;
        end
      end
      cpdt_pkg::CS_ARM:
      begin
        // firing needs the ramp under way whatever the early time
        if (!s_reg.ctl.enable)
        begin
          s_next.cut_st = cpdt_pkg::CS_IDLE;
        end
        else if (die_ramp && (die_at_min || early_hit)) // [RL9] [RL11]
        begin
          s_next.cut_st  = cpdt_pkg::CS_DOWN;
          s_next.cut_cnt = 14'h0000;
        end
      end
      cpdt_pkg::CS_DOWN:
      begin
        s_next.cut_cnt = s_reg.cut_cnt + {13'h0000, s_reg.tick}; // [RL21]
        // the switch wins over any dwell still left
        if (((s_reg.ctl.cut_sw_fit || zero_dn) && s_reg.cut_sw2) || // [RL4]
            (!zero_dn && s_reg.cut_cnt >= s_reg.cut_dn)) // [RL1] [RL8]
        begin
          s_next.cut_st = cpdt_pkg::CS_UP;
        end
        else if (zero_dn && s_reg.cut_cnt >= `CPDT_TIMEOUT_MS)
        begin
          s_next.cut_st = cpdt_pkg::CS_UP;
          s_next.err    = 1'b1;                         // [RL3] [RL5]
          s_next.halt   = 1'b1;                         // [RL3] [RL5]
        end
        if (s_next.cut_st == cpdt_pkg::CS_UP)
        begin
          s_next.tol_pulse = 1'b1;                              // [RL12]
          s_next.cut_cnt   = 14'h0000;
          s_next.up_len    = s_reg.ctl.combined ?
                             s_reg.cut_cnt :                    // [RL7]
                             s_reg.cut_up;                      // [RL6]
        end
      end
      cpdt_pkg::CS_UP:
      begin
        s_next.cut_cnt = s_reg.cut_cnt + {13'h0000, s_reg.tick};
        if (s_reg.cut_cnt >= s_reg.up_len)                      // [RL6]
        begin
          s_next.cut_st = cpdt_pkg::CS_IDLE;
        end
      end
      default:
      begin
        s_next.cut_st = cpdt_pkg::CS_IDLE;
      end
    endcase

    // one timer per press, each with its own settings
    for (int i = 0; i < 4; i++)
    begin
      unique case (s_reg.prs[i].st)
        cpdt_pkg::PS_IDLE:
        begin
          if (press_req[i] && s_reg.ctl.enable)
          begin
            s_next.prs[i].st  = cpdt_pkg::PS_DOWN;              // [RL20]
            s_next.prs[i].cnt = 14'h0000;
          end
        end
        cpdt_pkg::PS_DOWN:
        begin
          s_next.prs[i].cnt = s_reg.prs[i].cnt + {13'h0000, s_reg.tick};
          if ((s_reg.ctl.prs_sw_fit[i] && s_reg.prs_sw2[i]) || // [RL16]
              s_reg.prs[i].cnt >= s_reg.prs_dn[i])             // [RL14]
          begin
            s_next.prs[i].st  = cpdt_pkg::PS_UP;
            s_next.prs[i].cnt = 14'h0000;
            s_next.prs[i].len = s_reg.ctl.combined ?
                                s_reg.prs[i].cnt :              // [RL18]
                                s_reg.prs_up[i];                // [RL17]
          end
        end
        cpdt_pkg::PS_UP:
        begin
          s_next.prs[i].cnt = s_reg.prs[i].cnt + {13'h0000, s_reg.tick};
          if (s_reg.prs[i].cnt >= s_reg.prs[i].len)             // [RL17]
          begin
            s_next.prs[i].st = cpdt_pkg::PS_IDLE;
          end
        end
        default:
        begin
          s_next.prs[i].st = cpdt_pkg::PS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // register
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg <= S_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // zero wait states keep the slave simple; the timers need no stall
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_reg.rdata;

  // solenoid levels decode straight from one-hot state flops
  always_comb
  begin
    solenoids.cut    = (s_reg.cut_st == cpdt_pkg::CS_DOWN);   // [RL20]
    solenoids.cut_up = (s_reg.cut_st == cpdt_pkg::CS_UP);
    for (int j = 0; j < 4; j++)
    begin
      solenoids.press[j]    = (s_reg.prs[j].st == cpdt_pkg::PS_DOWN);
      solenoids.press_up[j] = (s_reg.prs[j].st == cpdt_pkg::PS_UP);
    end
  end

  assign tol_check       = s_reg.tol_pulse;
  assign line_halt       = s_reg.halt;
  assign error_flag      = s_reg.err;
  assign restart_inhibit = inhibit;

endmodule : cpdt_top

// ### common/cpdt_regs.svh
`ifndef CPDT_REGS_SVH
`define CPDT_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CPDT_CTRL_OFS      8'h00
`define CPDT_CUT_DN_OFS    8'h04
`define CPDT_CUT_UP_OFS    8'h08
`define CPDT_EARLY_OFS     8'h0C
`define CPDT_STATUS_OFS    8'h10
`define CPDT_PDN_BASE      4'h2
`define CPDT_PUP_BASE      4'h3

// ****************************************************************
// field positions and widths
// ****************************************************************
`define CPDT_CTRL_W        10
`define CPDT_DWELL_W       14
`define CPDT_EARLY_W       9
`define CPDT_STS_CLR_BIT   0

// ****************************************************************
// reset values and limits, in ms
// ****************************************************************
`define CPDT_DWELL_RST     14'h00C8
`define CPDT_EARLY_RST     9'h000
`define CPDT_DWELL_MAX     14'h270F
`define CPDT_DWELL_MIN     14'h0001
`define CPDT_EARLY_MAX     9'h1F4
`define CPDT_TIMEOUT_MS    14'h2710

// ****************************************************************
// timing
// ****************************************************************
`define CPDT_CLK_NS        40
`define CPDT_TICK_NS       1000000
`define CPDT_TICK_CYC      (`CPDT_TICK_NS / `CPDT_CLK_NS)

`endif

// ### common/cpdt_pkg.sv
package cpdt_pkg;

  // ****************************************************************
  // modes and states
  // ****************************************************************
  typedef enum logic [1:0] {
    TOL_CUT_STOP = 2'h0,
    TOL_WARN     = 2'h1,
    TOL_STOP     = 2'h2,
    TOL_RSVD     = 2'h3
  } cpdt_tol_e;

  typedef enum logic [3:0] {
    CS_IDLE = 4'h1,
    CS_ARM  = 4'h2,
    CS_DOWN = 4'h4,
    CS_UP   = 4'h8
  } cpdt_cut_e;

  typedef enum logic [2:0] {
    PS_IDLE = 3'h1,
    PS_DOWN = 3'h2,
    PS_UP   = 3'h4
  } cpdt_prs_e;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [3:0] prs_sw_fit;
    cpdt_tol_e  tol_act;
    logic       cut_sw_fit;
    logic       combined;
    logic       nonstop;
    logic       enable;
  } cpdt_ctl_s;

  typedef struct packed {
    logic       cut;
    logic       cut_up;
    logic [3:0] press;
    logic [3:0] press_up;
  } cpdt_sol_s;

  typedef struct packed {
    cpdt_prs_e   st;
    logic [13:0] cnt;
    logic [13:0] len;
  } cpdt_prs_s;

  typedef struct packed {
    cpdt_ctl_s            ctl;
    logic [13:0]          cut_dn;
    logic [13:0]          cut_up;
    logic [8:0]           early;
    logic [3:0][13:0]     prs_dn;
    logic [3:0][13:0]     prs_up;
    logic [14:0]          tick_cnt;
    logic                 tick;
    cpdt_cut_e            cut_st;
    logic [13:0]          cut_cnt;
    logic [13:0]          up_len;
    logic                 err;
    logic                 halt;
    logic                 tol_pulse;
    cpdt_prs_s [3:0]      prs;
    logic                 cut_sw1;
    logic                 cut_sw2;
    logic [3:0]           prs_sw1;
    logic [3:0]           prs_sw2;
    logic                 wr_pend;
    logic [7:0]           a_addr;
    logic [31:0]          rdata;
  } cpdt_state_s;

endpackage : cpdt_pkg

// ### dv/cpdt_asserts.sv
`timescale 1ns/100ps
// ********
// stroke timing checks
// ********
module cpdt_chk (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                die_ramp,
  input wire logic [3:0]          press_req,
  input wire cpdt_pkg::cpdt_sol_s solenoids,
  input wire logic                tol_check,
  input wire logic                line_halt,
  input wire logic                error_flag,
  input wire logic                restart_inhibit
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // the cut stroke leaves the bottom
  sequence s_cut_end;
    $fell(solenoids.cut);
  endsequence
  // length check pulse for exactly one cycle
  sequence s_tol_pulse;
    tol_check ##1 !tol_check;
  endsequence

  a_tol_at_end: assert property (s_cut_end |-> s_tol_pulse)
    else $error("no single check pulse at end of cut");
  a_tol_cause: assert property (tol_check |-> s_cut_end)
    else $error("check pulse without end of cut");
  a_cut_after_ramp: assert property (
    $rose(solenoids.cut) |-> $past(die_ramp))
    else $error("cut fired before die ramp");
  a_up_follows: assert property (
    s_cut_end |-> solenoids.cut_up && !solenoids.cut)
    else $error("cut up not started after down stroke");
  a_press_apart: assert property (
    (solenoids.press & solenoids.press_up) == 4'h0)
    else $error("press down and up both on");
  // a press only fires on its own request
  a_press_cause: assert property (
    (solenoids.press & ~$past(solenoids.press) & ~$past(press_req))
      == 4'h0)
    else $error("press fired without request");
  a_err_halts: assert property ($rose(error_flag) |-> line_halt)
    else $error("error without line halt");
  a_halt_held: assert property (
    $fell(line_halt) || $fell(error_flag)
      |-> $past(hsel && htrans[1] && hwrite, 2))
    else $error("halt or error dropped without clear write");
  a_inhibit_cut: assert property (
    restart_inhibit |-> solenoids.cut)
    else $error("restart held without cut stroke");
endmodule : cpdt_chk

// ### dv/cpdt_press_model.sv
`timescale 1ns/100ps
// ********
// solenoids and stroke complete switches
// ********
module cpdt_press_model (
  input  wire logic                hclk,
  input  wire cpdt_pkg::cpdt_sol_s solenoids,
  input  wire logic                sw_en,
  input  wire logic [15:0]         sw_dly,
  output logic                     cut_sw_pin,
  output logic [3:0]               press_sw_pin
);
  logic [4:0][15:0] trav;
  logic [4:0]       fire;
  logic [4:0]       closed;

  assign fire = {solenoids.cut, solenoids.press};
  assign {cut_sw_pin, press_sw_pin} = closed;

  // cycles of travel since each solenoid was energised
  always_ff @(posedge hclk)
    for (int i = 0; i < 5; i++)
      trav[i] <= fire[i] ? trav[i] + 16'h1 : 16'h0;

  // switch closes at the bottom; released it reads open, not last value
  always_comb
    for (int i = 0; i < 5; i++)
      closed[i] = sw_en && fire[i] && trav[i] >= sw_dly;
endmodule : cpdt_press_model

// ### dv/tb_cut_press_dwell_timer.sv
`timescale 1ns/100ps
// ********
// bench for cut and press dwell timing
// ********
module tb_cut_press_dwell_timer;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
  } cpdt_rrow_s;
  typedef struct packed {
    logic [1:0] tol;
    logic [8:0] early;
    logic       ramp;
    logic       atmin;
    logic [8:0] eta;
    logic       fire;
  } cpdt_erow_s;
  // short tick keeps the 10 s timeout near 20000 cycles
  localparam int TK = 2;
  logic                hclk, hresetn, hsel, hwrite, hready, hresp;
  logic                cut_req, die_ramp, die_at_min, cut_sw_pin;
  logic                tol_check, line_halt, error_flag, restart_inhibit;
  logic                sw_en, f;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [3:0]          press_req, press_sw_pin;
  logic [8:0]          die_eta_ms;
  logic [15:0]         sw_dly;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  cpdt_pkg::cpdt_sol_s solenoids;
  int                  mismatches, n_tests, i, dn, up, tc, ri;
  int                  dw [3] = '{1, 5, 9999};
  cpdt_rrow_s rrows [10] = '{
    '{8'h04, 32'h0, 32'h0},        // zero dwell kept
    '{8'h04, 32'd20000, 32'h270F},
    '{8'h04, 32'h1, 32'h1},
    '{8'h0C, 32'd600, 32'h1F4},
    '{8'h20, 32'h0, 32'h1},
    '{8'h2C, 32'd9999, 32'h270F},
    '{8'h08, 32'h3FFF, 32'h270F},
    '{8'h40, 32'h5, 32'h0},        // unmapped
    '{8'h10, 32'h0, 32'h0},        // status; a zero write clears nothing
    '{8'h00, 32'h2A5, 32'h2A5}};
  cpdt_rrow_s zrows [5] = '{'{8'h00, 0, 32'h0}, '{8'h04, 0, 32'hC8},
    '{8'h0C, 0, 32'h0}, '{8'h34, 0, 32'hC8}, '{8'h10, 0, 32'h0}};
  cpdt_erow_s erows [8] = '{
    '{2'h0, 9'd5, 1'b0, 1'b1, 9'd0, 1'b0},
    '{2'h0, 9'd5, 1'b1, 1'b0, 9'd3, 1'b1},
    '{2'h1, 9'd5, 1'b1, 1'b0, 9'd5, 1'b1},
    '{2'h2, 9'd5, 1'b1, 1'b0, 9'd3, 1'b0},
    '{2'h3, 9'd5, 1'b1, 1'b0, 9'd3, 1'b0},
    '{2'h0, 9'd5, 1'b1, 1'b0, 9'd6, 1'b0},
    '{2'h0, 9'd0, 1'b1, 1'b0, 9'd0, 1'b0},
    '{2'h2, 9'd0, 1'b1, 1'b1, 9'd9, 1'b1}};

  cpdt_top #(.TICK_CYCLES(TK)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .cut_req(cut_req), .die_ramp(die_ramp),
    .die_at_min(die_at_min), .die_eta_ms(die_eta_ms),
    .cut_sw_pin(cut_sw_pin), .press_req(press_req),
    .press_sw_pin(press_sw_pin), .solenoids(solenoids),
    .tol_check(tol_check), .line_halt(line_halt),
    .error_flag(error_flag), .restart_inhibit(restart_inhibit));

  cpdt_press_model far_u (
    .hclk(hclk), .solenoids(solenoids), .sw_en(sw_en),
    .sw_dly(sw_dly), .cut_sw_pin(cut_sw_pin),
    .press_sw_pin(press_sw_pin));

  // ********
  // checking and bus tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic rng(input string nm, input int v, lo, hi);
    chk(nm, 32'(v >= lo && v <= hi), 32'h1);
  endtask : rng

  // holds address phase, then data phase, until hready is sampled high
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 100);
    q = hrdata;
  endtask : ahb

  function automatic logic [1:0] sol(input int ch);
    if (ch == 4)
      return {solenoids.cut, solenoids.cut_up};
    return {solenoids.press[ch], solenoids.press_up[ch]};
  endfunction : sol

  // one stroke on channel ch (4 = cut); counts down and up cycles
  task automatic do_op(input int ch, output int dn, up, tc, ri);
    int n;
    {dn, up, tc, ri, n} = '0;
    @(posedge hclk);
    if (ch == 4)
      cut_req <= 1'b1;
    else
      press_req <= 4'h1 << ch;
    @(posedge hclk);
    cut_req <= 1'b0;
    press_req <= 4'h0;
    while (sol(ch) !== 2'b10 && n++ < 60) @(posedge hclk);
    while (sol(ch) === 2'b10 && dn < 30000)
    begin
      ri += (restart_inhibit !== 1'b0); // an unknown counts, never hides
      @(posedge hclk);
      dn++;
    end
    while (sol(ch) === 2'b01 && up < 30000)
    begin
      tc += (tol_check !== 1'b0);
      @(posedge hclk);
      up++;
    end
  endtask : do_op

  // arm a cut under given die state, see if it fires, then finish it
  task automatic early_row(input cpdt_erow_s r, output logic f);
    int n;
    n = 0;
    ahb(1'b1, 8'h00, 32'({r.tol, 4'h1}), rd);
    ahb(1'b1, 8'h0C, 32'(r.early), rd);
    die_ramp <= r.ramp;
    die_at_min <= r.atmin;
    die_eta_ms <= r.eta;
    cut_req <= 1'b1;
    @(posedge hclk);
    cut_req <= 1'b0;
    f = 1'b0;
    repeat (20) @(posedge hclk) f |= solenoids.cut;
    die_ramp <= 1'b1;
    die_at_min <= 1'b1;
    repeat (3) @(posedge hclk);
    while ((solenoids.cut | solenoids.cut_up) !== 0 && n++ < 3000)
      @(posedge hclk);
  endtask : early_row

  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // ********
  // clock, watchdog and main sequence
  // ********
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // a hang counts as a failure
  initial
  begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    complete_run();
  end

  initial
  begin
    {hresetn, hsel, hwrite, cut_req, sw_en} = '0;
    {htrans, press_req, haddr, hwdata, die_eta_ms, sw_dly} = '0;
    {die_ramp, die_at_min, hsize} = {2'b11, 3'h2};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 10; i++)
    begin
      ahb(1'b1, rrows[i].a, rrows[i].d, rd);
      ahb(1'b0, rrows[i].a, 32'h0, rd);
      chk("reg", rd, rrows[i].x);
    end
    $display("done: register limits");
    // reset again in mid-run, then look at reset values
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      ahb(1'b0, zrows[i].a, 32'h0, rd);
      chk("rst", rd, zrows[i].x);
    end
    $display("done: reset values");
    ahb(1'b1, 8'h00, 32'h1, rd);
    ahb(1'b1, 8'h08, 32'h2, rd);
    for (i = 0; i < 3; i++)
    begin
      ahb(1'b1, 8'h04, 32'(dw[i]), rd);
      do_op(4, dn, up, tc, ri);
      rng("cut_dn", dn, TK*dw[i]-TK, TK*dw[i]+1);
      rng("cut_up", up, 2*TK-TK, 2*TK+1);
      chk("tol", tc, 1);
    end
    $display("done: cut dwell");
    sw_en <= 1'b1;
    sw_dly <= 16'd20;
    ahb(1'b1, 8'h00, 32'hD, rd);
    ahb(1'b1, 8'h04, 32'd50, rd); // dwell above switch time
    do_op(4, dn, up, tc, ri);
    rng("sw_dn", dn, 20, 26);
    rng("comb_up", up, dn-4, dn+4);
    ahb(1'b1, 8'h00, 32'h1, rd);
    ahb(1'b1, 8'h04, 32'h0, rd);
    sw_dly <= 16'd30;
    do_op(4, dn, up, tc, ri);
    rng("zero_dn", dn, 30, 36);
    rng("inhibit", ri, dn-1, dn);
    chk("no_err", {line_halt, error_flag}, 0);
    $display("done: switch end");
    sw_en <= 1'b0;
    ahb(1'b1, 8'h00, 32'h3, rd);
    do_op(4, dn, up, tc, ri);
    rng("tmo", dn, 10000*TK-4, 10000*TK+4);
    chk("run_on", ri, 0);
    chk("halt", {line_halt, error_flag}, 2'b11);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk("sts", rd, 32'h3);
    ahb(1'b1, 8'h10, 32'h1, rd);
    ahb(1'b0, 8'h10, 32'h0, rd);
    chk("sts_clr", rd, 32'h0);
    $display("done: timeout");
    ahb(1'b1, 8'h04, 32'h5, rd);
    for (i = 0; i < 8; i++)
    begin
      early_row(erows[i], f);
      chk("fire", f, erows[i].fire);
    end
    $display("done: early start");
    ahb(1'b1, 8'h00, 32'h1, rd);
    for (i = 0; i < 4; i++)
    begin
      ahb(1'b1, 8'h20 + 8'(4*i), 32'(2+i), rd);
      ahb(1'b1, 8'h30 + 8'(4*i), 32'h3, rd);
      do_op(i, dn, up, tc, ri);
      rng("prs_dn", dn, 2*i+2, 2*i+5);
      rng("prs_up", up, 4, 7);
    end
    sw_en <= 1'b1;
    sw_dly <= 16'd20;
    ahb(1'b1, 8'h00, 32'h205, rd);
    ahb(1'b1, 8'h2C, 32'd50, rd);
    do_op(3, dn, up, tc, ri);
    rng("prs_sw", dn, 20, 26);
    rng("prs_comb", up, dn-4, dn+4);
    $display("done: presses");
    complete_run();
  end
endmodule : tb_cut_press_dwell_timer

bind cpdt_top cpdt_chk chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .die_ramp(die_ramp), .press_req(press_req),
  .solenoids(solenoids), .tol_check(tol_check),
  .line_halt(line_halt), .error_flag(error_flag),
  .restart_inhibit(restart_inhibit));
